// *** logic/adctm_pkg.sv ***
// Constants shared by the converter control device end and its CPU end.
// Assumes byte-wide registers at fixed 32-bit byte addresses.
package adctm_pkg;
   localparam logic [31:0] ADDR_RES0_LOW = 32'hFFFFF300;
   localparam logic [31:0] ADDR_RES0_HIGH = 32'hFFFFF301;
   localparam logic [31:0] ADDR_MON_CTRL = 32'hFFFFF31B;
   localparam logic [31:0] ADDR_TRIG_CTRL = 32'hFFFFF31C;
   localparam int MON_EN_BIT = 0;
   localparam int MON_SEL_LSB = 1;
   localparam int MON_PRIO_SEL_BIT = 4;
   localparam int MON_IRQ_BIT = 5;
   localparam int MON_RSV_BIT = 7;
   localparam logic [7:0] MON_WMASK = 8'hBF;
   localparam logic [7:0] MON_CTRL_RST = 8'h00;
   localparam int TRIG_NORM_EN_BIT = 4;
   localparam int TRIG_NORM_SRC_BIT = 5;
   localparam int TRIG_PRI_EN_BIT = 6;
   localparam int TRIG_PRI_SRC_BIT = 7;
   localparam logic [3:0] TRIG_CTRL_RST = 4'h0;
   localparam logic [1:0] RST_CODE_ARM = 2'h2;
   localparam logic [1:0] RST_CODE_FIRE = 2'h1;
   localparam int LOW_OVR_BIT = 1;
   localparam int LOW_STORED_BIT = 0;
   localparam logic [7:0] LOW_ONES = 8'h3C;
   localparam logic SRC_EXT = 1'h0;
   localparam logic SRC_TIMER = 1'h1;
   localparam int RESULT_W = 10;
   typedef enum logic [2:0] {
      ADCTM_CMD_READ,
      ADCTM_CMD_WRITE,
      ADCTM_CMD_SOFT_RESET,
      ADCTM_CMD_PIN_FUNC,
      ADCTM_CMD_TIMER_RUN
   } adctm_cmd_t;
endpackage

// *** logic/adctm_if.sv ***
// Byte register bus between the CPU end and the converter control end.
// Assumes both ends share one clock; strobes are single-cycle.
`timescale 1ns/1ps
interface adctm_if;
   logic [31:0] addr;
   logic wr_en;
   logic rd_en;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rd_valid;
   modport dev (
      input addr,
      input wr_en,
      input rd_en,
      input wdata,
      output rdata,
      output rd_valid
   );
   modport cpu (
      output addr,
      output wr_en,
      output rd_en,
      output wdata,
      input rdata,
      input rd_valid
   );
endinterface

// *** logic/adctm_dev.sv ***
// Converter control device end: monitor select, hardware start, soft reset
// and result pair zero. Assumes the CPU end keeps the software ordering.
`timescale 1ns/1ps

// Behaviour
// - Monitor compares pair chosen by select code
// - Enable bit lets hardware source start conversion
// - Source bit picks pin or timer interrupt
// - Software sets pin function before trigger use
// - Select timer, enable, then run timer
// - Soft reset before changing start source
// - Disable start before freeing trigger pin
// - High byte holds result bits nine..two
// - Low byte bits seven, six hold bits one..zero
// - Low byte bit one is overrun flag
// - Store sets bit zero, and bit one if a result is unread; low read clears both
// - Low byte bits two..five read ones
module adctm_dev #(
   parameter int RESULT_W = 10
) (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, high
   adctm_if.dev bus, // CPU register bus
   input wire logic external_conv_trigger_n, // Trigger pin, active low
   input wire logic timer0_interrupt, // Timer 0 pulse
   input wire logic timer1_interrupt, // Timer 1 pulse
   input wire logic conv_store, // Result ready pulse
   input wire logic [RESULT_W-1:0] conv_result, // Converted value
   output logic normal_hw_start, // Normal start pulse
   output logic priority_hw_start, // Priority start pulse
   output logic converter_soft_reset, // Soft reset pulse
   output logic monitor_enable, // Monitor on
   output logic monitor_irq_condition, // Monitor interrupt condition
   output logic [2:0] monitor_pair_index, // Compared pair index
   output logic monitor_priority_pair // Compare priority pair
);

   if (RESULT_W != adctm_pkg::RESULT_W) begin : g_bad_width
      $error("Result width must be ten bits");
   end

   // Trigger pin synchroniser and falling edge
   logic trig_s1;
   logic trig_s2;
   logic trig_prev;
   logic next_trig_prev;
   logic ext_fall;

   always_comb begin
      next_trig_prev = trig_s2;
      ext_fall = trig_prev & ~trig_s2;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trig_s1 <= 1'h1;
         trig_s2 <= 1'h1;
         trig_prev <= 1'h1;
      end else begin
         trig_s1 <= external_conv_trigger_n;
         trig_s2 <= trig_s1;
         trig_prev <= next_trig_prev;
      end
   end

   // Control registers
   logic [7:0] mon_ctrl;
   logic [3:0] trig_ctrl;
   logic rst_armed;
   logic [7:0] next_mon_ctrl;
   logic [3:0] next_trig_ctrl;
   logic next_rst_armed;
   logic next_soft_reset;
   logic next_normal_start;
   logic next_priority_start;
   logic wr_mon;
   logic wr_trig;
   logic [1:0] rst_code;

   always_comb begin
      wr_mon = bus.wr_en && (bus.addr == adctm_pkg::ADDR_MON_CTRL);
      wr_trig = bus.wr_en && (bus.addr == adctm_pkg::ADDR_TRIG_CTRL);
      rst_code = bus.wdata[1:0];
      next_mon_ctrl = mon_ctrl;
      next_trig_ctrl = trig_ctrl;
      next_rst_armed = rst_armed;
      next_soft_reset = 1'h0;
      if (wr_mon) begin
         // Unused bit six stays zero
         next_mon_ctrl = bus.wdata & adctm_pkg::MON_WMASK;
      end
      if (wr_trig) begin
         next_trig_ctrl = bus.wdata[7:4];
         // Any other code breaks the two-write sequence
         next_rst_armed = (rst_code == adctm_pkg::RST_CODE_ARM);
         next_soft_reset = rst_armed && (rst_code == adctm_pkg::RST_CODE_FIRE);
      end
      next_normal_start = 1'h0;
      next_priority_start = 1'h0;
      if (trig_ctrl[adctm_pkg::TRIG_NORM_EN_BIT - 4]) begin
         next_normal_start = (trig_ctrl[adctm_pkg::TRIG_NORM_SRC_BIT - 4] == adctm_pkg::SRC_TIMER)
            ? timer0_interrupt : ext_fall;
      end
      if (trig_ctrl[adctm_pkg::TRIG_PRI_EN_BIT - 4]) begin
         next_priority_start = (trig_ctrl[adctm_pkg::TRIG_PRI_SRC_BIT - 4] == adctm_pkg::SRC_TIMER)
            ? timer1_interrupt : ext_fall;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mon_ctrl <= adctm_pkg::MON_CTRL_RST;
         trig_ctrl <= adctm_pkg::TRIG_CTRL_RST;
         rst_armed <= 1'h0;
         converter_soft_reset <= 1'h0;
         normal_hw_start <= 1'h0;
         priority_hw_start <= 1'h0;
      end else begin
         mon_ctrl <= next_mon_ctrl;
         trig_ctrl <= next_trig_ctrl;
         rst_armed <= next_rst_armed;
         converter_soft_reset <= next_soft_reset;
         normal_hw_start <= next_normal_start;
         priority_hw_start <= next_priority_start;
      end
   end

   // Monitor selection straight from the control register
   always_comb begin
      monitor_enable = mon_ctrl[adctm_pkg::MON_EN_BIT];
      monitor_irq_condition = mon_ctrl[adctm_pkg::MON_IRQ_BIT];
      monitor_pair_index = mon_ctrl[adctm_pkg::MON_SEL_LSB +: 3];
      // Any code with top bit set means the priority pair
      monitor_priority_pair = mon_ctrl[adctm_pkg::MON_PRIO_SEL_BIT];
   end

   // Result pair zero
   logic [RESULT_W-1:0] res_data;
   logic stored;
   logic ovr;
   logic [RESULT_W-1:0] next_res_data;
   logic next_stored;
   logic next_ovr;
   logic rd_low;

   always_comb begin
      rd_low = bus.rd_en && (bus.addr == adctm_pkg::ADDR_RES0_LOW);
      next_res_data = res_data;
      next_stored = stored;
      next_ovr = ovr;
      if (rd_low || converter_soft_reset) begin
         next_stored = 1'h0;
         next_ovr = 1'h0;
      end
      // Store wins over a read in the same cycle
      if (conv_store) begin
         next_res_data = conv_result;
         next_stored = 1'h1;
         if (stored && !rd_low) begin
            next_ovr = 1'h1;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         res_data <= '0;
         stored <= 1'h0;
         ovr <= 1'h0;
      end else begin
         res_data <= next_res_data;
         stored <= next_stored;
         ovr <= next_ovr;
      end
   end

   // Read path, one cycle after the strobe
   function automatic logic [7:0] read_byte(input logic [31:0] a);
      logic [7:0] v;
      v = 8'h00;
      unique case (a)
         adctm_pkg::ADDR_RES0_LOW: begin
            v = {res_data[1:0], 6'h00} | adctm_pkg::LOW_ONES;
            v[adctm_pkg::LOW_OVR_BIT] = ovr;
            v[adctm_pkg::LOW_STORED_BIT] = stored;
         end
         adctm_pkg::ADDR_RES0_HIGH: v = res_data[9:2];
         adctm_pkg::ADDR_MON_CTRL: v = mon_ctrl;
         // Reset code field is write-only and reads zero
         adctm_pkg::ADDR_TRIG_CTRL: v = {trig_ctrl, 4'h0};
         default: v = 8'h00;
      endcase
      return v;
   endfunction

   logic [7:0] next_rdata;
   logic next_rd_valid;

   always_comb begin
      next_rdata = bus.rd_en ? read_byte(bus.addr) : bus.rdata;
      next_rd_valid = bus.rd_en;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bus.rdata <= 8'h00;
         bus.rd_valid <= 1'h0;
      end else begin
         bus.rdata <= next_rdata;
         bus.rd_valid <= next_rd_valid;
      end
   end

endmodule

// *** logic/adctm_cpu.sv ***
// CPU end: issues register reads and writes, the two-write soft reset,
// and guards the trigger pin and timer ordering against misuse.
`timescale 1ns/1ps
module adctm_cpu (
   input wire logic clk, // System clock
   input wire logic rst, // Async reset, high
   adctm_if.cpu bus, // Register bus to device
   input wire logic cmd_valid, // Command offered
   input wire adctm_pkg::adctm_cmd_t cmd_kind, // Command kind
   input wire logic [31:0] cmd_addr, // Register byte address
   input wire logic [7:0] cmd_data, // Write data or bit 0 level
   output logic cmd_ready, // Command can be taken
   output logic cmd_refused, // One-cycle pulse after a refused command is taken
   output logic resp_valid, // Read data pulse
   output logic [7:0] resp_data, // Read data
   output logic trigger_pin_function_bit, // Pin set to trigger use
   output logic timer_run // Timers allowed to run
);
   typedef enum logic [1:0] {S_IDLE, S_RD_WAIT, S_RST2} adctm_cpu_state_t;
   adctm_cpu_state_t state, next_state;
   logic [3:0] shadow, next_shadow;
   logic since_rst, next_since_rst;
   logic [31:0] next_addr;
   logic [7:0] next_wdata;
   logic next_wr, next_rd, next_refused, next_resp_valid;
   logic [7:0] next_resp_data;
   logic next_pin, next_timer;
   logic bad;
   logic take;
   logic [3:0] nt;

   // Refuse a start setting that breaks the pin, timer or reset ordering
   function automatic logic bad_pair(input logic en, input logic src, input logic old_src,
                                     input logic pin, input logic since);
      return (en && src == adctm_pkg::SRC_EXT && !pin)
         || (en && src != old_src)
         || (src != old_src && !since);
   endfunction

   always_comb begin
      cmd_ready = (state == S_IDLE);
      take = cmd_valid && cmd_ready;
      nt = cmd_data[7:4];
      next_state = state;
      next_shadow = shadow;
      next_since_rst = since_rst;
      next_addr = bus.addr;
      next_wdata = bus.wdata;
      next_wr = 1'h0;
      next_rd = 1'h0;
      next_refused = 1'h0;
      next_resp_valid = 1'h0;
      next_resp_data = resp_data;
      next_pin = trigger_pin_function_bit;
      next_timer = timer_run;
      bad = 1'h0;
      unique case (state)
         S_IDLE: if (take) begin
            unique case (cmd_kind)
               adctm_pkg::ADCTM_CMD_READ: begin
                  next_addr = cmd_addr;
                  next_rd = 1'h1;
                  next_state = S_RD_WAIT;
               end
               adctm_pkg::ADCTM_CMD_WRITE: begin
                  if (cmd_addr == adctm_pkg::ADDR_TRIG_CTRL) begin
                     bad = bad_pair(nt[0], nt[1], shadow[1], trigger_pin_function_bit, since_rst)
                        || bad_pair(nt[2], nt[3], shadow[3], trigger_pin_function_bit, since_rst);
                  end
                  if (!bad) begin
                     next_addr = cmd_addr;
                     next_wdata = cmd_data;
                     if (cmd_addr == adctm_pkg::ADDR_MON_CTRL) begin
                        next_wdata[adctm_pkg::MON_RSV_BIT] = 1'h0;
                     end
                     if (cmd_addr == adctm_pkg::ADDR_TRIG_CTRL) begin
                        next_wdata[1:0] = 2'h0;
                        next_shadow = nt;
                        if (nt[1] != shadow[1] || nt[3] != shadow[3]) begin
                           next_since_rst = 1'h0;
                        end
                     end
                     next_wr = 1'h1;
                  end
               end
               adctm_pkg::ADCTM_CMD_SOFT_RESET: begin
                  next_addr = adctm_pkg::ADDR_TRIG_CTRL;
                  next_wdata = {shadow, 2'h0, adctm_pkg::RST_CODE_ARM};
                  next_wr = 1'h1;
                  next_state = S_RST2;
               end
               adctm_pkg::ADCTM_CMD_PIN_FUNC: begin
                  // Pin stays with the trigger while an external start is on
                  bad = !cmd_data[0] && ((shadow[0] && shadow[1] == adctm_pkg::SRC_EXT)
                     || (shadow[2] && shadow[3] == adctm_pkg::SRC_EXT));
                  if (!bad) begin
                     next_pin = cmd_data[0];
                  end
               end
               adctm_pkg::ADCTM_CMD_TIMER_RUN: begin
                  bad = cmd_data[0] && !((shadow[0] && shadow[1] == adctm_pkg::SRC_TIMER)
                     || (shadow[2] && shadow[3] == adctm_pkg::SRC_TIMER));
                  if (!bad) begin
                     next_timer = cmd_data[0];
                  end
               end
               default: bad = 1'h1;
            endcase
            next_refused = bad;
         end
         S_RD_WAIT: if (bus.rd_valid) begin
            next_resp_valid = 1'h1;
            next_resp_data = bus.rdata;
            next_state = S_IDLE;
         end
         S_RST2: begin
            next_wdata = {shadow, 2'h0, adctm_pkg::RST_CODE_FIRE};
            next_wr = 1'h1;
            next_since_rst = 1'h1;
            next_state = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= S_IDLE;
         shadow <= adctm_pkg::TRIG_CTRL_RST;
         since_rst <= 1'h1;
         bus.addr <= 32'h00000000;
         bus.wdata <= 8'h00;
         bus.wr_en <= 1'h0;
         bus.rd_en <= 1'h0;
         cmd_refused <= 1'h0;
         resp_valid <= 1'h0;
         resp_data <= 8'h00;
         trigger_pin_function_bit <= 1'h0;
         timer_run <= 1'h0;
      end else begin
         state <= next_state;
         shadow <= next_shadow;
         since_rst <= next_since_rst;
         bus.addr <= next_addr;
         bus.wdata <= next_wdata;
         bus.wr_en <= next_wr;
         bus.rd_en <= next_rd;
         cmd_refused <= next_refused;
         resp_valid <= next_resp_valid;
         resp_data <= next_resp_data;
         trigger_pin_function_bit <= next_pin;
         timer_run <= next_timer;
      end
   end
endmodule

// *** verification/adctm_properties.sv ***
// Checker on the bus between the two ends and on the device's outputs.
// Instantiated beside the interface; every input is a plain signal.
`timescale 1ns/1ps
module adctm_properties (
   input wire logic clk, // Clock
   input wire logic rst, // Reset
   input wire logic [31:0] addr, // Bus address
   input wire logic wr_en, // Write strobe
   input wire logic rd_en, // Read strobe
   input wire logic [7:0] wdata, // Write data
   input wire logic [7:0] rdata, // Read data
   input wire logic rd_valid, // Read answer
   input wire logic timer0_interrupt, // Timer 0
   input wire logic normal_hw_start, // Normal start
   input wire logic converter_soft_reset, // Soft reset
   input wire logic monitor_enable, // Monitor on
   input wire logic [2:0] monitor_pair_index, // Pair index
   input wire logic monitor_priority_pair // Priority pair
);
   logic [7:0] trig;
   logic [7:0] mon;
   wire w_trig = wr_en && addr == adctm_pkg::ADDR_TRIG_CTRL;
   wire w_mon = wr_en && addr == adctm_pkg::ADDR_MON_CTRL;
   wire fire = w_trig && wdata[1:0] == 2'h1;
   wire norm_en = trig[4];
   // Shadows follow the bus, so refused commands never reach them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         trig <= 8'h00;
         mon <= 8'h00;
      end else begin
         trig <= w_trig ? wdata : trig;
         mon <= w_mon ? wdata : mon;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_rd_ans; rd_en |=> rd_valid; endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
   property p_rd_src; rd_valid |-> $past(rd_en); endproperty
   a_rd_src: assert property (p_rd_src) else $error("answer without read");
   property p_ones; rd_en && addr == adctm_pkg::ADDR_RES0_LOW |=> rdata[5:2] == 4'hF; endproperty
   a_ones: assert property (p_ones) else $error("low byte unused bits not ones");
   property p_b7; rd_en && addr == adctm_pkg::ADDR_MON_CTRL |=> !rdata[7]; endproperty
   a_b7: assert property (p_b7) else $error("monitor bit 7 set");
   property p_srst; (w_trig && wdata[1:0] == 2'h2) ##1 fire |=> converter_soft_reset; endproperty
   a_srst: assert property (p_srst) else $error("soft reset missing");
   property p_srst_src; converter_soft_reset |-> $past(fire); endproperty
   a_srst_src: assert property (p_srst_src) else $error("soft reset without code");
   property p_en; normal_hw_start |-> $past(norm_en); endproperty
   a_en: assert property (p_en) else $error("start while disabled");
   property p_tmr; timer0_interrupt && trig[4] && trig[5] |=> normal_hw_start; endproperty
   a_tmr: assert property (p_tmr) else $error("timer start missing");
   property p_mon; w_mon |=> {monitor_priority_pair, monitor_pair_index, monitor_enable} == mon[4:0]; endproperty
   a_mon: assert property (p_mon) else $error("monitor select wrong");
   c_srst: cover property (converter_soft_reset);
   c_tmr: cover property (timer0_interrupt && trig[5] ##1 normal_hw_start);
   c_prio: cover property (w_mon && wdata[4]);
endmodule

// *** verification/test_adc_trigger_monitor_result.sv ***
// Testbench: CPU end and device end joined by the register bus.
// Drives the CPU command port and the device's converter-side inputs.
`timescale 1ns/1ps
module test_adc_trigger_monitor_result;
   localparam logic [31:0] LO = adctm_pkg::ADDR_RES0_LOW;
   localparam logic [31:0] HI = adctm_pkg::ADDR_RES0_HIGH;
   localparam logic [31:0] MC = adctm_pkg::ADDR_MON_CTRL;
   localparam logic [31:0] TC = adctm_pkg::ADDR_TRIG_CTRL;
   localparam adctm_pkg::adctm_cmd_t RD = adctm_pkg::ADCTM_CMD_READ;
   localparam adctm_pkg::adctm_cmd_t WR = adctm_pkg::ADCTM_CMD_WRITE;
   localparam adctm_pkg::adctm_cmd_t SR = adctm_pkg::ADCTM_CMD_SOFT_RESET;
   localparam adctm_pkg::adctm_cmd_t PF = adctm_pkg::ADCTM_CMD_PIN_FUNC;
   localparam adctm_pkg::adctm_cmd_t TR = adctm_pkg::ADCTM_CMD_TIMER_RUN;
   typedef struct packed {logic [7:0] w; logic [7:0] r; logic [5:0] o;} adctm_row_t;
   // Outputs as {irq, priority, index, enable}; bit 7 is forced low by the CPU end
   localparam adctm_row_t ROWS [5] = '{'{8'h01, 8'h01, 6'h01}, '{8'h0F, 8'h0F, 6'h0F},
      '{8'h13, 8'h13, 6'h13}, '{8'h2A, 8'h2A, 6'h2A}, '{8'hFF, 8'h3F, 6'h3F}};
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cmd_valid = 1'b0;
   adctm_pkg::adctm_cmd_t cmd_kind = RD;
   logic [31:0] cmd_addr = 32'h0;
   logic [7:0] cmd_data = 8'h00;
   logic pin_n = 1'b1;
   logic t0 = 1'b0;
   logic t1 = 1'b0;
   logic cs = 1'b0;
   logic [9:0] cres = 10'h000;
   logic cmd_ready, cmd_refused, resp_valid, pin_fn, trun, nst, pst, srst, men, mirq, mpr;
   logic [7:0] resp_data;
   logic [2:0] midx;
   int failures = 0;
   int check_count = 0;
   always #4 clk = ~clk;
   adctm_if link();
   adctm_dev i_adctm_dev (.clk(clk), .rst(rst), .bus(link.dev), .external_conv_trigger_n(pin_n),
      .timer0_interrupt(t0), .timer1_interrupt(t1), .conv_store(cs), .conv_result(cres),
      .normal_hw_start(nst), .priority_hw_start(pst), .converter_soft_reset(srst), .monitor_enable(men),
      .monitor_irq_condition(mirq), .monitor_pair_index(midx), .monitor_priority_pair(mpr));
   adctm_cpu i_adctm_cpu (.clk(clk), .rst(rst), .bus(link.cpu), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
      .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready), .cmd_refused(cmd_refused),
      .resp_valid(resp_valid), .resp_data(resp_data), .trigger_pin_function_bit(pin_fn), .timer_run(trun));
   adctm_properties i_adctm_properties (.clk(clk), .rst(rst), .addr(link.addr), .wr_en(link.wr_en),
      .rd_en(link.rd_en), .wdata(link.wdata), .rdata(link.rdata), .rd_valid(link.rd_valid),
      .timer0_interrupt(t0), .normal_hw_start(nst), .converter_soft_reset(srst), .monitor_enable(men),
      .monitor_pair_index(midx), .monitor_priority_pair(mpr));
   task automatic print_verdict;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         $display("BAD %s exp %h got %h", what, exp, got);
         failures++;
      end
   endtask
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   // Returns just after the take edge, when strobes and refusal show
   task automatic go(input adctm_pkg::adctm_cmd_t k, input logic [31:0] a, input logic [7:0] d, input logic r);
      int n;
      n = 0;
      while (cmd_ready !== 1'b1) begin
         tick();
         n++;
         if (n > 20) begin
            failures++;
            print_verdict();
         end
      end
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_kind <= k;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
      chk("refused", {7'h0, r}, {7'h0, cmd_refused});
   endtask
   // Read answer stands two edges after the take edge
   task automatic rd(input logic [31:0] a, input logic [7:0] e, input string w);
      go(RD, a, 8'h00, 1'b0);
      tick();
      tick();
      chk("valid", 8'h01, {7'h0, resp_valid});
      chk(w, e, resp_data);
   endtask
   task automatic store(input logic [9:0] v);
      @(posedge clk);
      cs <= 1'b1;
      cres <= v;
      @(posedge clk);
      cs <= 1'b0;
      #1;
   endtask
   task automatic tmr(input logic which, input logic [7:0] e);
      @(posedge clk);
      t0 <= !which;
      t1 <= which;
      @(posedge clk);
      t0 <= 1'b0;
      t1 <= 1'b0;
      #1;
      chk("starts", e, {6'h0, pst, nst});
   endtask
   initial begin
      int n;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      #1;
      for (int i = 0; i < 5; i++) begin
         go(WR, MC, ROWS[i].w, 1'b0);
         tick();
         chk("mon out", {2'h0, ROWS[i].o}, {2'h0, mirq, mpr, midx, men});
         rd(MC, ROWS[i].r, "mon rd");
      end
      rd(TC, 8'h00, "trig rst");
      rd(LO, 8'h3C, "low rst");
      rd(32'hFFFFF310, 8'h00, "unmapped");
      store(10'h2D6);
      rd(HI, 8'hB5, "high");
      rd(LO, 8'hBD, "low");
      rd(LO, 8'hBC, "low again");
      store(10'h001);
      store(10'h3FF);
      rd(LO, 8'hFF, "overrun");
      rd(LO, 8'hFC, "overrun clr");
      go(TR, 32'h0, 8'h01, 1'b1);
      go(WR, TC, 8'hA0, 1'b0);
      go(WR, TC, 8'hF0, 1'b0);
      go(TR, 32'h0, 8'h01, 1'b0);
      chk("timer run", 8'h01, {7'h0, trun});
      tmr(1'b0, 8'h01);
      tmr(1'b1, 8'h02);
      rd(TC, 8'hF0, "trig rd");
      go(WR, TC, 8'hA0, 1'b0);
      tmr(1'b0, 8'h00);
      go(WR, TC, 8'h00, 1'b1);
      store(10'h155);
      go(SR, 32'h0, 8'h00, 1'b0);
      tick();
      tick();
      chk("soft reset", 8'h01, {7'h0, srst});
      rd(LO, 8'h7C, "low after reset");
      go(WR, TC, 8'h00, 1'b0);
      go(WR, TC, 8'h10, 1'b1);
      go(PF, 32'h0, 8'h01, 1'b0);
      go(WR, TC, 8'h50, 1'b0);
      @(posedge clk);
      pin_n <= 1'b0;
      n = 0;
      while (nst !== 1'b1 && n < 8) begin
         tick();
         n++;
      end
      chk("pin start", 8'h03, {6'h0, pst, nst});
      @(posedge clk);
      pin_n <= 1'b1;
      go(PF, 32'h0, 8'h00, 1'b1);
      go(WR, TC, 8'h00, 1'b0);
      go(PF, 32'h0, 8'h00, 1'b0);
      chk("pin func", 8'h00, {7'h0, pin_fn});
      // Mid-run reset with timer running, monitor set and a result stored
      store(10'h2D6);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("run after rst", 8'h00, {7'h0, trun});
      chk("mon out rst", 8'h00, {2'h0, mirq, mpr, midx, men});
      rd(MC, 8'h00, "mon after rst");
      rd(TC, 8'h00, "trig after rst");
      rd(LO, 8'h3C, "low after rst");
      print_verdict();
   end
endmodule
